// ---- pdoc_defs.svh ----
// register offsets, field positions, reset values and loop constants
`ifndef PDOC_DEFS_SVH
`define PDOC_DEFS_SVH

// oscillator group
`define PDOC_OFS_SLOW_TRIM        8'h04
`define PDOC_OFS_PLL_CFG          8'h05
`define PDOC_OFS_REF_SEL          8'h06

// calibration loop groups: base plus local offset
`define PDOC_BASE_LOOP_MED        8'h10
`define PDOC_BASE_LOOP_FAST       8'h18
`define PDOC_LOC_CTRL             3'h0
`define PDOC_LOC_FINE             3'h2
`define PDOC_LOC_RANGE            3'h3
`define PDOC_LOC_RATIO_LO         3'h5
`define PDOC_LOC_RATIO_HI         3'h6

// pll configuration fields
`define PDOC_PLL_SRC_HI           7
`define PDOC_PLL_SRC_LO           6
`define PDOC_PLL_HALVE_BIT        5
`define PDOC_PLL_MULT_HI          4
`define PDOC_PLL_MULT_LO          0
`define PDOC_PLL_CFG_RST          8'h00

// loop reference select fields
`define PDOC_REF_FAST_HI          2
`define PDOC_REF_FAST_LO          1
`define PDOC_REF_MED_BIT          0
`define PDOC_REF_SEL_RST          8'h00

// calibration value layout
`define PDOC_FINE_W               7
`define PDOC_RANGE_W              6
`define PDOC_CAL_W                13
`define PDOC_FINE_MAX             7'h7f
`define PDOC_FINE_MIN             7'h00

// ratio reset values: nominal frequency over a 1.024 kHz reference
`define PDOC_RATIO_MED_RST        16'h07a1
`define PDOC_RATIO_FAST_RST       16'h7a12
`define PDOC_RATIO_SAT            16'hffff

`endif

// ---- pdoc_pkg.sv ----
// types shared by the pll and oscillator calibration block
package pdoc_pkg;

    typedef enum logic [2:0] {
        PDOC_LOOP_IDLE = 3'b001,
        PDOC_LOOP_RUN  = 3'b010,
        PDOC_LOOP_STOP = 3'b100
    } pdoc_loop_state_t;

    typedef enum logic [1:0] {
        PDOC_PLL_SRC_MED  = 2'b00,
        PDOC_PLL_SRC_RSVD = 2'b01,
        PDOC_PLL_SRC_FAST = 2'b10,
        PDOC_PLL_SRC_EXT  = 2'b11
    } pdoc_pll_src_t;

    typedef enum logic [1:0] {
        PDOC_REF_INT_SLOW = 2'b00,
        PDOC_REF_CRYSTAL  = 2'b01,
        PDOC_REF_RSVD2    = 2'b10,
        PDOC_REF_RSVD3    = 2'b11
    } pdoc_ref_sel_t;

endpackage

// ---- pdoc_edge_det.sv ----
// rising edge detector for a sampled oscillator level
`timescale 1ns/1ps
module pdoc_edge_det
(
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic level_in,
    output logic      rise_out
);
    logic level_r;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            level_r <= 1'b0;
        else
            level_r <= level_in;
    end

    assign rise_out = level_in & ~level_r;
endmodule

// ---- pdoc_period_ctr.sv ----
// counts oscillator edges across one reference period
`timescale 1ns/1ps
`include "pdoc_defs.svh"
module pdoc_period_ctr
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        run_in,
    input  wire logic        osc_rise_in,
    input  wire logic        ref_rise_in,
    output logic [15:0]      count_out,
    output logic             done_out
);
    logic [15:0] cnt_r;
    logic        primed_r;
    logic        done_r;

    // the first reference edge only opens a window; a partial period would mislead
    always_ff @(posedge clk_in)
    begin
        if (srst_in || !run_in)
            primed_r <= 1'b0;
        else if (ref_rise_in)
            primed_r <= 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in || !run_in || ref_rise_in)
            cnt_r <= 16'h0000;
        else if (osc_rise_in && cnt_r != `PDOC_RATIO_SAT)
            cnt_r <= cnt_r + 16'h0001;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            done_r    <= 1'b0;
            count_out <= 16'h0000;
        end
        else
        begin
            done_r <= run_in & ref_rise_in & primed_r;
            if (run_in && ref_rise_in && primed_r)
                count_out <= cnt_r;
        end
    end

    assign done_out = done_r;
endmodule

// ---- pdoc_top.sv ----
// pll configuration and frequency locked calibration loops for the internal oscillators
`timescale 1ns/1ps
`include "pdoc_defs.svh"
// Rules for this block and for the software that drives it
// RULE1: slow trim loads factory value, software rewrites
// RULE2: pll input select picks pll reference
// RULE3: software never uses crystal as pll reference
// RULE4: halve bit divides pll output by two
// RULE5: multiplier field sets factor one to 31
// RULE6: fast loop reference selects slow sources
// RULE7: medium loop reference bit resets to zero
// RULE8: software enables chosen reference separately
// RULE9: enable bit starts automatic oscillator calibration
// RULE10: enable reads one until loop stopped
// RULE11: calibration value is 13 bits, split
// RULE12: disabled loop uses registers; software writes
// RULE13: enabled loop ignores calibration register writes
// RULE14: reset loads factory calibration, reserved zero
// RULE15: loop adjusts only the fine part
// RULE16: software centres fine part for range
// RULE17: 16-bit ratio split over two registers
// RULE18: ratio resets to nominal over 1.024kHz
// RULE19: loop counts, compares and steps fine part
module pdoc_top
    import pdoc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [7:0]       rdata_out,
    input  wire logic [7:0]  factory_trim_in,
    input  wire logic [6:0]  factory_fine_med_in,
    input  wire logic [5:0]  factory_range_med_in,
    input  wire logic [6:0]  factory_fine_fast_in,
    input  wire logic [5:0]  factory_range_fast_in,
    input  wire logic        internal_32khz_oscillator_in,
    input  wire logic        slow_crystal_reference_in,
    input  wire logic        internal_2mhz_oscillator_in,
    input  wire logic        internal_32mhz_oscillator_in,
    output logic [7:0]       slow_oscillator_trim_out,
    output logic [1:0]       pll_input_select_out,
    output logic             pll_input_valid_out,
    output logic             pll_output_halve_out,
    output logic [4:0]       pll_multiplier_out,
    output logic             pll_multiplier_valid_out,
    output logic [12:0]      med_osc_cal_out,
    output logic [12:0]      fast_osc_cal_out,
    output logic [1:0]       loop_active_out
);
    localparam int NLOOP = 2;

    logic [7:0]  slow_trim_r;
    logic [7:0]  pll_cfg_r;
    logic [7:0]  ref_sel_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    logic [NLOOP-1:0]      en_r;
    logic [NLOOP-1:0]      busy;
    logic [6:0]            fine_r   [NLOOP];
    logic [5:0]            range_r  [NLOOP];
    logic [15:0]           ratio_r  [NLOOP];
    logic [6:0]            fac_fine [NLOOP];
    logic [5:0]            fac_rng  [NLOOP];
    logic [15:0]           ratio_rst[NLOOP];
    logic [7:0]            base     [NLOOP];
    logic [NLOOP-1:0]      grp_hit;
    logic [NLOOP-1:0]      osc_lvl;
    logic [NLOOP-1:0]      ref_lvl;
    logic [NLOOP-1:0]      ref_ok;
    logic [NLOOP-1:0]      run;
    logic [NLOOP-1:0]      osc_rise;
    logic [NLOOP-1:0]      ref_rise;
    logic [NLOOP-1:0]      done;
    logic [15:0]           count    [NLOOP];
    pdoc_loop_state_t      state_r  [NLOOP];
    pdoc_loop_state_t      state_nxt[NLOOP];
    logic [7:0]            loop_rd  [NLOOP];

    pdoc_ref_sel_t fast_ref;

    assign fast_ref = pdoc_ref_sel_t'(ref_sel_r[`PDOC_REF_FAST_HI:`PDOC_REF_FAST_LO]);

    // loop 0 tunes the 2 MHz oscillator, loop 1 the 32 MHz oscillator
    assign fac_fine[0]  = factory_fine_med_in;
    assign fac_fine[1]  = factory_fine_fast_in;
    assign fac_rng[0]   = factory_range_med_in;
    assign fac_rng[1]   = factory_range_fast_in;
    assign ratio_rst[0] = `PDOC_RATIO_MED_RST;
    assign ratio_rst[1] = `PDOC_RATIO_FAST_RST;
    assign base[0]      = `PDOC_BASE_LOOP_MED;
    assign base[1]      = `PDOC_BASE_LOOP_FAST;
    assign osc_lvl[0]   = internal_2mhz_oscillator_in;
    assign osc_lvl[1]   = internal_32mhz_oscillator_in;

    // RULE7: medium reference bit choice
    // RULE6: fast reference choice
    // both loops share one process so every bit of ref_lvl has a single driver
    always_comb
    begin
        ref_lvl[0] = ref_sel_r[`PDOC_REF_MED_BIT] ? slow_crystal_reference_in
                                                  : internal_32khz_oscillator_in;
        ref_ok[0]  = 1'b1;
        case (fast_ref)
            PDOC_REF_INT_SLOW:
            begin
                ref_lvl[1] = internal_32khz_oscillator_in;
                ref_ok[1]  = 1'b1;
            end
            PDOC_REF_CRYSTAL:
            begin
                ref_lvl[1] = slow_crystal_reference_in;
                ref_ok[1]  = 1'b1;
            end
            // reserved codes give the loop no reference, so it never steps
            default:
            begin
                ref_lvl[1] = 1'b0;
                ref_ok[1]  = 1'b0;
            end
        endcase
    end

    // RULE1: slow trim load and rewrite
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            slow_trim_r <= factory_trim_in;
        else if (wr_in && addr_in == `PDOC_OFS_SLOW_TRIM)
            slow_trim_r <= wdata_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            pll_cfg_r <= `PDOC_PLL_CFG_RST;
        else if (wr_in && addr_in == `PDOC_OFS_PLL_CFG)
            pll_cfg_r <= wdata_in;
    end

    // reserved upper bits of the reference select are never stored
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            ref_sel_r <= `PDOC_REF_SEL_RST;
        else if (wr_in && addr_in == `PDOC_OFS_REF_SEL)
            ref_sel_r <= {5'h00, wdata_in[2:0]};
    end

    genvar g;
    generate
        for (g = 0; g < NLOOP; g++)
        begin : g_loop
            logic hit_ctrl;
            logic hit_fine;
            logic hit_range;
            logic hit_lo;
            logic hit_hi;

            assign grp_hit[g] = addr_in[7:3] == base[g][7:3];
            assign hit_ctrl   = grp_hit[g] && addr_in[2:0] == `PDOC_LOC_CTRL;
            assign hit_fine   = grp_hit[g] && addr_in[2:0] == `PDOC_LOC_FINE;
            assign hit_range  = grp_hit[g] && addr_in[2:0] == `PDOC_LOC_RANGE;
            assign hit_lo     = grp_hit[g] && addr_in[2:0] == `PDOC_LOC_RATIO_LO;
            assign hit_hi     = grp_hit[g] && addr_in[2:0] == `PDOC_LOC_RATIO_HI;

            // RULE9: software enable request
            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                    en_r[g] <= 1'b0;
                else if (wr_in && hit_ctrl)
                    en_r[g] <= wdata_in[0];
            end

            // RULE10: busy until the loop reaches idle
            assign busy[g] = state_r[g] != PDOC_LOOP_IDLE;
            assign run[g]  = state_r[g] == PDOC_LOOP_RUN && ref_ok[g];

            always_comb
            begin
                case (state_r[g])
                    PDOC_LOOP_IDLE:
                        state_nxt[g] = en_r[g] ? PDOC_LOOP_RUN : PDOC_LOOP_IDLE;
                    PDOC_LOOP_RUN:
                        state_nxt[g] = en_r[g] ? PDOC_LOOP_RUN : PDOC_LOOP_STOP;
                    // one quiet cycle lets a final compare result drain
                    PDOC_LOOP_STOP:
                        state_nxt[g] = PDOC_LOOP_IDLE;
                    default:
                        state_nxt[g] = PDOC_LOOP_IDLE;
                endcase
            end

            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                    state_r[g] <= PDOC_LOOP_IDLE;
                else
                    state_r[g] <= state_nxt[g];
            end

            pdoc_edge_det u_osc_edge
            (
                .clk_in   (clk_in),
                .srst_in  (srst_in),
                .level_in (osc_lvl[g]),
                .rise_out (osc_rise[g])
            );

            pdoc_edge_det u_ref_edge
            (
                .clk_in   (clk_in),
                .srst_in  (srst_in),
                .level_in (ref_lvl[g]),
                .rise_out (ref_rise[g])
            );

            // RULE19: count oscillator per reference
            pdoc_period_ctr u_period
            (
                .clk_in      (clk_in),
                .srst_in     (srst_in),
                .run_in      (run[g]),
                .osc_rise_in (osc_rise[g]),
                .ref_rise_in (ref_rise[g]),
                .count_out   (count[g]),
                .done_out    (done[g])
            );

            // RULE14: factory fine value at reset
            // RULE13: writes dropped while busy
            // RULE19: step fine part toward ratio
            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                    fine_r[g] <= fac_fine[g];
                else if (busy[g])
                begin
                    if (done[g] && state_r[g] == PDOC_LOOP_RUN)
                    begin
                        if (count[g] > ratio_r[g] && fine_r[g] != `PDOC_FINE_MIN)
                            fine_r[g] <= fine_r[g] - 7'h01;
                        else if (count[g] < ratio_r[g] && fine_r[g] != `PDOC_FINE_MAX)
                            fine_r[g] <= fine_r[g] + 7'h01;
                    end
                end
                // RULE12: manual write when disabled
                // en_r closes the gap between the enabling write and the run state
                else if (wr_in && hit_fine && !en_r[g])
                    fine_r[g] <= wdata_in[6:0];
            end

            // RULE15: loop never touches range part
            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                    range_r[g] <= fac_rng[g];
                else if (wr_in && hit_range && !busy[g] && !en_r[g])
                    range_r[g] <= wdata_in[5:0];
            end

            // RULE18: nominal ratio at reset
            // RULE17: ratio bytes written separately
            always_ff @(posedge clk_in)
            begin
                if (srst_in)
                    ratio_r[g] <= ratio_rst[g];
                else if (wr_in && hit_lo)
                    ratio_r[g][7:0] <= wdata_in;
                else if (wr_in && hit_hi)
                    ratio_r[g][15:8] <= wdata_in;
            end

            always_comb
            begin
                case (addr_in[2:0])
                    `PDOC_LOC_CTRL:     loop_rd[g] = {7'h00, en_r[g] | busy[g]};
                    `PDOC_LOC_FINE:     loop_rd[g] = {1'b0, fine_r[g]};
                    `PDOC_LOC_RANGE:    loop_rd[g] = {2'b00, range_r[g]};
                    `PDOC_LOC_RATIO_LO: loop_rd[g] = ratio_r[g][7:0];
                    `PDOC_LOC_RATIO_HI: loop_rd[g] = ratio_r[g][15:8];
                    default:            loop_rd[g] = 8'h00;
                endcase
            end
        end
    endgenerate

    // RULE14: reserved bits read as zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (grp_hit[0])
            rdata_nxt = loop_rd[0];
        else if (grp_hit[1])
            rdata_nxt = loop_rd[1];
        else
        begin
            case (addr_in)
                `PDOC_OFS_SLOW_TRIM: rdata_nxt = slow_trim_r;
                `PDOC_OFS_PLL_CFG:   rdata_nxt = pll_cfg_r;
                `PDOC_OFS_REF_SEL:   rdata_nxt = ref_sel_r;
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            rdata_r <= 8'h00;
        else if (rd_in)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= 8'h00;
    end

    assign rdata_out = rdata_r;

    // RULE2: pll reference select output
    // RULE3: reserved code flagged invalid
    assign pll_input_select_out = pll_cfg_r[`PDOC_PLL_SRC_HI:`PDOC_PLL_SRC_LO];
    assign pll_input_valid_out  = pdoc_pll_src_t'(pll_input_select_out) != PDOC_PLL_SRC_RSVD;

    // RULE4: halve pll output
    assign pll_output_halve_out = pll_cfg_r[`PDOC_PLL_HALVE_BIT];

    // RULE5: multiplier factor, zero unusable
    assign pll_multiplier_out       = pll_cfg_r[`PDOC_PLL_MULT_HI:`PDOC_PLL_MULT_LO];
    assign pll_multiplier_valid_out = pll_multiplier_out != 5'h00;

    assign slow_oscillator_trim_out = slow_trim_r;

    // RULE11: range above fine in 13 bits
    assign med_osc_cal_out  = {range_r[0], fine_r[0]};
    assign fast_osc_cal_out = {range_r[1], fine_r[1]};
    assign loop_active_out  = busy;
endmodule

// ---- pdoc_monitor.sv ----
// concurrent checks on the ports of the pll and oscillator calibration block
`timescale 1ns/1ps
module pdoc_monitor
(
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic [7:0]  addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic [7:0]  factory_trim_in,
    input wire logic [6:0]  factory_fine_med_in,
    input wire logic [5:0]  factory_range_med_in,
    input wire logic [7:0]  slow_oscillator_trim_out,
    input wire logic [1:0]  pll_input_select_out,
    input wire logic        pll_input_valid_out,
    input wire logic        pll_output_halve_out,
    input wire logic [4:0]  pll_multiplier_out,
    input wire logic        pll_multiplier_valid_out,
    input wire logic [12:0] med_osc_cal_out,
    input wire logic [12:0] fast_osc_cal_out,
    input wire logic [1:0]  loop_active_out
);
    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    read_data_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside read answer cycle");
    pll_fields_a: assert property (wr_in && addr_in == 8'h05 |=>
        {pll_input_select_out, pll_output_halve_out, pll_multiplier_out} == $past(wdata_in))
        else $error("pll fields differ from written value");
    src_valid_a: assert property (pll_input_valid_out == (pll_input_select_out != 2'b01))
        else $error("pll source valid flag wrong");
    mult_valid_a: assert property (pll_multiplier_valid_out == (pll_multiplier_out != 5'h00))
        else $error("pll multiplier valid flag wrong");
    trim_write_a: assert property (wr_in && addr_in == 8'h04 |=>
        slow_oscillator_trim_out == $past(wdata_in))
        else $error("slow trim not updated by write");
    reset_defaults_a: assert property ($fell(srst_in) |-> loop_active_out == 2'b00 &&
        med_osc_cal_out == {factory_range_med_in, factory_fine_med_in} &&
        slow_oscillator_trim_out == factory_trim_in && pll_input_select_out == 2'b00)
        else $error("values after reset wrong");
    range_hold_a: assert property ($past(loop_active_out[0]) |->
        $stable(med_osc_cal_out[12:7]))
        else $error("range part changed while loop active");
    fine_step_a: assert property ($past(loop_active_out[1]) |->
        7'(fast_osc_cal_out[6:0] - $past(fast_osc_cal_out[6:0])) inside {7'h00, 7'h01, 7'h7f})
        else $error("fine part moved by more than one step");
    enable_start_a: assert property (wr_in && addr_in == 8'h10 && wdata_in[0] |=>
        ##1 loop_active_out[0])
        else $error("loop not active after enable");
    enable_stop_a: assert property (wr_in && addr_in == 8'h18 && !wdata_in[0] |->
        ##[1:3] !loop_active_out[1])
        else $error("loop still active after disable");

    cover property (wr_in && addr_in == 8'h05);
    cover property ($past(loop_active_out[0]) && $changed(med_osc_cal_out[6:0]));
    cover property ($fell(loop_active_out[1]));
endmodule

bind pdoc_top pdoc_monitor pdoc_monitor_inst (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .factory_trim_in(factory_trim_in),
    .factory_fine_med_in(factory_fine_med_in), .factory_range_med_in(factory_range_med_in),
    .slow_oscillator_trim_out(slow_oscillator_trim_out),
    .pll_input_select_out(pll_input_select_out), .pll_input_valid_out(pll_input_valid_out),
    .pll_output_halve_out(pll_output_halve_out), .pll_multiplier_out(pll_multiplier_out),
    .pll_multiplier_valid_out(pll_multiplier_valid_out), .med_osc_cal_out(med_osc_cal_out),
    .fast_osc_cal_out(fast_osc_cal_out), .loop_active_out(loop_active_out));

// ---- tb_pdoc_top.sv ----
// self-checking bench for the pll and oscillator calibration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if (16'(g) !== 16'(e)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", n, 16'(e), 16'(g)); end end
module tb_pdoc_top;
    localparam logic [7:0] f_trim   = 8'h5a;
    localparam logic [6:0] f_fine_m = 7'h15;
    localparam logic [5:0] f_rng_m  = 6'h2a;
    localparam logic [6:0] f_fine_f = 7'h33;
    localparam logic [5:0] f_rng_f  = 6'h11;
    logic        clk_in, srst_in, wr_in, rd_in, valid_out, halve_out, mvalid_out;
    logic [7:0]  addr_in, wdata_in, rdata_out, trim_out, cnt_r, v;
    logic [1:0]  src_out, active_out;
    logic [4:0]  mult_out;
    logic [12:0] med_out, fast_out;
    logic [4:0]  mtab [4] = '{5'h00, 5'h01, 5'h10, 5'h1f};
    int          failures, total_checks, cyc, i;

    // oscillators are slow divided levels of the bench counter, sampled by the block
    pdoc_top pdoc_top_inst (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .factory_trim_in(f_trim), .factory_fine_med_in(f_fine_m),
        .factory_range_med_in(f_rng_m), .factory_fine_fast_in(f_fine_f),
        .factory_range_fast_in(f_rng_f), .internal_32khz_oscillator_in(cnt_r[5]),
        .slow_crystal_reference_in(cnt_r[6]), .internal_2mhz_oscillator_in(cnt_r[2]),
        .internal_32mhz_oscillator_in(cnt_r[1]), .slow_oscillator_trim_out(trim_out),
        .pll_input_select_out(src_out), .pll_input_valid_out(valid_out),
        .pll_output_halve_out(halve_out), .pll_multiplier_out(mult_out),
        .pll_multiplier_valid_out(mvalid_out), .med_osc_cal_out(med_out),
        .fast_osc_cal_out(fast_out), .loop_active_out(active_out));

    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_in)
    begin
        cnt_r <= cnt_r + 8'h01;
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        @(negedge clk_in);
        `CHK("rdata", e, rdata_out)
    endtask

    initial
    begin
        srst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        cnt_r = 8'h00;
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(8'h04, f_trim);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h12, {1'b0, f_fine_m});
        rd(8'h13, {2'b00, f_rng_m});
        rd(8'h1a, {1'b0, f_fine_f});
        rd(8'h1b, {2'b00, f_rng_f});
        rd(8'h15, 8'ha1);
        rd(8'h16, 8'h07);
        rd(8'h1d, 8'h12);
        rd(8'h1e, 8'h7a);
        `CHK("med cal", {f_rng_m, f_fine_m}, med_out);
        $display("test reset done");
        for (i = 0; i < 4; i++)
        begin
            v = {i[1:0], i[0], mtab[i]};
            wr(8'h05, v);
            @(negedge clk_in);
            `CHK("pll source", i[1:0], src_out);
            `CHK("pll valid", i != 1, valid_out);
            `CHK("pll halve", i[0], halve_out);
            `CHK("pll mult", mtab[i], mult_out);
            `CHK("mult valid", i != 0, mvalid_out);
            rd(8'h05, v);
        end
        $display("test pll done");
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h07);
        wr(8'h04, 8'hc3);
        rd(8'h04, 8'hc3);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        rd(8'h11, 8'h00);
        wr(8'h12, 8'hff);
        wr(8'h13, 8'hff);
        @(negedge clk_in);
        `CHK("med cal", 13'h1fff, med_out);
        rd(8'h12, 8'h7f);
        rd(8'h13, 8'h3f);
        $display("test registers done");
        // medium loop: count below ratio, so the fine part must climb
        wr(8'h06, 8'h00);
        wr(8'h12, 8'h40);
        wr(8'h15, 8'hff);
        wr(8'h16, 8'h00);
        wr(8'h10, 8'h01);
        rd(8'h10, 8'h01);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h00);
        rd(8'h13, 8'h3f);
        repeat (400) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("fine up", 1'b1, med_out[6:0] > 7'h40);
        `CHK("range kept", 6'h3f, med_out[12:7]);
        wr(8'h10, 8'h00);
        repeat (4) @(posedge clk_in);
        rd(8'h10, 8'h00);
        wr(8'h12, 8'h40);
        rd(8'h12, 8'h40);
        $display("test medium loop done");
        // fast loop on the crystal: count above ratio, so the fine part must fall
        wr(8'h06, 8'h02);
        wr(8'h1a, 8'h40);
        wr(8'h1d, 8'h01);
        wr(8'h1e, 8'h00);
        wr(8'h18, 8'h01);
        repeat (700) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("fine down", 1'b1, fast_out[6:0] < 7'h40);
        `CHK("range kept", f_rng_f, fast_out[12:7]);
        wr(8'h18, 8'h00);
        repeat (4) @(posedge clk_in);
        $display("test fast loop done");
        // reserved reference: loop stays enabled but never steps
        wr(8'h06, 8'h04);
        wr(8'h1a, 8'h20);
        wr(8'h18, 8'h01);
        repeat (600) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("fine held", 7'h20, fast_out[6:0]);
        `CHK("loop active", 2'b10, active_out);
        rd(8'h18, 8'h01);
        wr(8'h18, 8'h00);
        repeat (4) @(posedge clk_in);
        rd(8'h18, 8'h00);
        $display("test reserved reference done");
        close_out();
    end
endmodule
